/* verilog/esf_defs.svh */
// Constants for the sensor error status word and its serial command set.
// Assumes a 16-bit frame: read flag in bit 15, address in 14:1, parity in 0.
`ifndef ESF_DEFS_SVH
`define ESF_DEFS_SVH

// ==========================================================================
// Frame layout
// ==========================================================================
`define ESF_FRAME_BITS      5'd16
`define ESF_CNT_MAX         5'd31
`define ESF_RW_BIT          15
`define ESF_ADDR_HI         14
`define ESF_ADDR_LO         1
`define ESF_PAR_BIT         0
`define ESF_EF_BIT          1

// ==========================================================================
// Command addresses
// ==========================================================================
`define ESF_ADDR_NOP        14'h0000
`define ESF_ADDR_POR_OFF    14'h3f22
`define ESF_ADDR_SOFT_RST   14'h3c00
`define ESF_ADDR_FULL_RST   14'h33a5
`define ESF_ADDR_CLR_ERR    14'h3380
`define ESF_ADDR_GAIN       14'h3ff8
`define ESF_ADDR_ANGLE      14'h3fff
`define ESF_ADDR_ERR_STAT   14'h335a
`define ESF_ADDR_SYS_CFG    14'h3f20

// ==========================================================================
// Error status word fields and reset values
// ==========================================================================
`define ESF_STAT_WIDTH      14
`define ESF_BIT_PENDING     4
`define ESF_BIT_BAD_ADDR    2
`define ESF_BIT_CLK_CNT     1
`define ESF_BIT_PARITY      0
`define ESF_STAT_RESET      14'h0000
`define ESF_TX_RESET        16'h0000

`endif

/* verilog/esf_pkg.sv */
// Types shared by the error status block.
// Assumes the constants header is compiled alongside.
package esf_pkg;

   // ========================================================================
   // Command classes
   // ========================================================================
   typedef enum logic [2:0] {
      cmd_other    = 3'b000,
      cmd_angle    = 3'b001,
      cmd_status   = 3'b010,
      cmd_clear    = 3'b011,
      cmd_full_rst = 3'b100,
      cmd_bad      = 3'b101
   } cmd_kind_t;

   // ========================================================================
   // Measurement tracker states
   // ========================================================================
   typedef enum logic [0:0] {
      meas_idle = 1'b0,
      meas_busy = 1'b1
   } meas_state_t;

endpackage : esf_pkg

/* verilog/esf_sync_bit.sv */
// Two-stage synchroniser for one level.
// Assumes the input is asynchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none

module esf_sync_bit (
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_async,
   output logic      o_sync
);

   logic stage1;

   // ========================================================================
   // Capture chain; first stage feeds only the second
   // ========================================================================
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stage1 <= 1'b1;
         o_sync <= 1'b1;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end

endmodule : esf_sync_bit

`default_nettype wire

/* verilog/error_status_sys_spi_flags.sv */
// Serial command front end and lower error status word of a position sensor.
// Assumes the host is the serial master, idles the select high for at least
// four core clocks between frames, and a measurement engine pulses done.
`timescale 1ns/1ps
`default_nettype none
`include "esf_defs.svh"

module error_status_sys_spi_flags (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_spi_sck,
   input  wire logic        i_spi_ss_n,
   input  wire logic        i_spi_mosi,
   input  wire logic        i_meas_done,
   output logic             o_spi_miso,
   output logic             o_spi_miso_oe,
   output logic             o_meas_start,
   output logic             o_meas_pending,
   output logic [13:0]      o_error_status
);

   // ========================================================================
   // Link side, clocked by the host serial clock
   // ========================================================================
   logic [15:0]             rx_shift;
   logic [4:0]              rx_cnt;
   logic [4:0]              tx_cnt;
   logic [15:0]             tx_word;

   logic                    frame_fresh;

   // Marks a new frame; select high arms it, first falling sck disarms it
   always_ff @(negedge i_spi_sck or posedge i_spi_ss_n or posedge i_sys_rst) begin
      if (i_sys_rst || i_spi_ss_n) begin
         frame_fresh <= 1'b1;
      end else begin
         frame_fresh <= 1'b0;
      end
   end

   // Count must outlive the select edge, the core reads it only after sync
   // Limitation: a frame with no clock at all leaves the previous count
   wire [4:0] next_rx_cnt = frame_fresh ? 5'd1
                          : (rx_cnt == `ESF_CNT_MAX) ? rx_cnt : rx_cnt + 5'd1;
   always_ff @(negedge i_spi_sck or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_cnt <= 5'd0;
      end else if (!i_spi_ss_n) begin
         rx_cnt <= next_rx_cnt;
      end
   end

   // Shift register keeps its contents across the select edge for the core
   always_ff @(negedge i_spi_sck or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_shift <= `ESF_TX_RESET;
      end else if (!i_spi_ss_n) begin
         rx_shift <= {rx_shift[14:0], i_spi_mosi};
      end
   end

   // Drive out on rising edge, msb first
   wire [3:0] tx_index = 4'hf - tx_cnt[3:0];
   always_ff @(posedge i_spi_sck or posedge i_spi_ss_n or posedge i_sys_rst) begin
      if (i_sys_rst || i_spi_ss_n) begin
         tx_cnt     <= 5'd0;
         o_spi_miso <= 1'b0;
      end else begin
         o_spi_miso <= (tx_cnt < `ESF_FRAME_BITS) ? tx_word[tx_index] : 1'b0;
         if (tx_cnt != `ESF_CNT_MAX) tx_cnt <= tx_cnt + 5'd1;
      end
   end

   // ========================================================================
   // Frame end detection in the core domain
   // ========================================================================
   logic                    ss_sync;
   logic                    ss_prev;
   logic                    frame_end;

   esf_sync_bit u_ss_sync (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    (i_spi_ss_n),
      .o_sync     (ss_sync)
   );

   // Rising select after sync; rx regs are quiet then, sck being idle
   wire next_frame_end = ss_sync && !ss_prev;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ss_prev       <= 1'b1;
         frame_end     <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else begin
         ss_prev       <= ss_sync;
         frame_end     <= next_frame_end;
         o_spi_miso_oe <= !ss_sync;
      end
   end

   // ========================================================================
   // Command checks and decode
   // ========================================================================
   logic [15:0]             cmd_word;
   logic [4:0]              cmd_cnt;

   // Word taken one cycle before frame_end, still stable
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmd_word <= `ESF_TX_RESET;
         cmd_cnt  <= 5'd0;
      end else if (next_frame_end) begin
         cmd_word <= rx_shift;
         cmd_cnt  <= rx_cnt;
      end
   end

   wire [13:0] cmd_addr  = cmd_word[`ESF_ADDR_HI:`ESF_ADDR_LO];
   wire        cmd_read  = cmd_word[`ESF_RW_BIT];
   wire        calc_par  = ^cmd_word[15:1];
   wire        err_par   = calc_par != cmd_word[`ESF_PAR_BIT];
   wire        err_clk   = cmd_cnt != `ESF_FRAME_BITS;
   wire        addr_ok   = (cmd_addr == `ESF_ADDR_NOP)
                        || (cmd_addr == `ESF_ADDR_POR_OFF)
                        || (cmd_addr == `ESF_ADDR_SOFT_RST)
                        || (cmd_addr == `ESF_ADDR_FULL_RST)
                        || (cmd_addr == `ESF_ADDR_CLR_ERR)
                        || (cmd_addr == `ESF_ADDR_GAIN)
                        || (cmd_addr == `ESF_ADDR_ANGLE)
                        || (cmd_addr == `ESF_ADDR_ERR_STAT)
                        || (cmd_addr == `ESF_ADDR_SYS_CFG);
   wire        err_addr  = !addr_ok;
   wire        frame_bad = err_par || err_clk || err_addr;

   // Faulty frames are never executed
   esf_pkg::cmd_kind_t cmd_kind;
   always_comb begin
      cmd_kind = esf_pkg::cmd_other;
      if (frame_bad)
         cmd_kind = esf_pkg::cmd_bad;
      else if (cmd_read && cmd_addr == `ESF_ADDR_ANGLE)
         cmd_kind = esf_pkg::cmd_angle;
      else if (cmd_read && cmd_addr == `ESF_ADDR_ERR_STAT)
         cmd_kind = esf_pkg::cmd_status;
      else if (cmd_addr == `ESF_ADDR_CLR_ERR)
         cmd_kind = esf_pkg::cmd_clear;
      else if (cmd_addr == `ESF_ADDR_FULL_RST)
         cmd_kind = esf_pkg::cmd_full_rst;
   end

   wire do_angle = frame_end && cmd_kind == esf_pkg::cmd_angle;
   wire do_stat  = frame_end && cmd_kind == esf_pkg::cmd_status;
   wire do_clear = frame_end && cmd_kind == esf_pkg::cmd_clear;
   wire do_reset = frame_end && cmd_kind == esf_pkg::cmd_full_rst;
   wire do_bad   = frame_end && cmd_kind == esf_pkg::cmd_bad;

   // ========================================================================
   // Sticky communication flags
   // ========================================================================
   logic                    flag_par;
   logic                    bad_address_flag;
   logic                    clock_count_error_flag;

   // Set wins over clear; clear or full reset wipes them
   wire wipe = do_clear || do_reset;
   wire next_flag_par  = (do_bad && err_par)  || (flag_par && !wipe);
   wire next_flag_addr = (do_bad && err_addr) || (bad_address_flag && !wipe);
   wire next_flag_clk  = (do_bad && err_clk)  || (clock_count_error_flag && !wipe);

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_par               <= 1'b0;
         bad_address_flag       <= 1'b0;
         clock_count_error_flag <= 1'b0;
      end else begin
         flag_par               <= next_flag_par;
         bad_address_flag       <= next_flag_addr;
         clock_count_error_flag <= next_flag_clk;
      end
   end

   // ========================================================================
   // Measurement tracker
   // ========================================================================
   esf_pkg::meas_state_t    meas_state;
   esf_pkg::meas_state_t    next_meas_state;

   // Full reset is the only way out if done never comes
   always_comb begin
      next_meas_state = meas_state;
      case (meas_state)
         esf_pkg::meas_idle: begin
            if (do_angle) next_meas_state = esf_pkg::meas_busy;
         end
         esf_pkg::meas_busy: begin
            if (do_reset)
               next_meas_state = esf_pkg::meas_idle;
            else if (i_meas_done)
               next_meas_state = esf_pkg::meas_idle;
         end
         default: next_meas_state = esf_pkg::meas_idle;
      endcase
   end

   // A read while busy does not restart the engine
   wire next_start = do_angle && meas_state == esf_pkg::meas_idle;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meas_state   <= esf_pkg::meas_idle;
         o_meas_start <= 1'b0;
      end else begin
         meas_state   <= next_meas_state;
         o_meas_start <= next_start;
      end
   end

   // ========================================================================
   // Status word and reply frame
   // ========================================================================
   wire pending = next_meas_state == esf_pkg::meas_busy;
   logic [13:0] next_status;
   always_comb begin
      next_status = `ESF_STAT_RESET;
      next_status[`ESF_BIT_PENDING]  = pending;
      next_status[`ESF_BIT_BAD_ADDR] = next_flag_addr;
      next_status[`ESF_BIT_CLK_CNT]  = next_flag_clk;
      next_status[`ESF_BIT_PARITY]   = next_flag_par;
   end

   wire       any_err  = next_flag_addr || next_flag_clk || next_flag_par;
   wire [13:0] reply_d = do_stat ? next_status : 14'h0000;
   wire [14:0] reply_u = {reply_d, any_err};
   wire [15:0] next_tx = {reply_u, ^reply_u};

   // Reply loaded only while the select is high, so the link sees it stable
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_word        <= `ESF_TX_RESET;
         o_error_status <= `ESF_STAT_RESET;
         o_meas_pending <= 1'b0;
      end else begin
         if (frame_end) tx_word <= next_tx;
         o_error_status <= next_status;
         o_meas_pending <= pending;
      end
   end

   // ========================================================================
   // Checks
   // ========================================================================
   AST_PEND_SET: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (do_angle && meas_state == esf_pkg::meas_idle)
         |=> o_meas_pending && o_error_status[4] && o_meas_start)
      else $error("pending not raised after angle read");

   AST_PEND_CLR: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (meas_state == esf_pkg::meas_busy && i_meas_done) |=> !o_meas_pending)
      else $error("pending not cleared on done");

   AST_PEND_HOLD: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_meas_pending && !i_meas_done && !do_reset) |=> o_meas_pending)
      else $error("pending dropped early");

   AST_DEADLOCK_EXIT: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      do_reset |=> !o_meas_pending && o_error_status == 14'h0000)
      else $error("full reset left flags set");

   AST_ADDR_FLAG: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (frame_end && err_addr) |=> o_error_status[2] && bad_address_flag)
      else $error("bad address not flagged");

   AST_CLK_FLAG: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (frame_end && cmd_cnt != 5'd16) |=> o_error_status[1])
      else $error("clock count fault not flagged");

   AST_PAR_FLAG: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (frame_end && (^cmd_word)) |=> o_error_status[0])
      else $error("parity fault not flagged");

   AST_STICKY: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($past(o_error_status[2]) && !$past(wipe)) |-> o_error_status[2])
      else $error("error flag lost without clear");

   AST_STATUS_REPLY: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      do_stat |=> tx_word[15:2] == o_error_status && !(^tx_word))
      else $error("status reply wrong");

endmodule : error_status_sys_spi_flags

`default_nettype wire

/* tb/esf_host_model.sv */
// Host side serial master model for the error status block.
// Assumes the bench resolves the reply line and calls frame() hierarchically.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Serial master
// ==========================================================================
module esf_host_model (
   input  wire logic i_miso,
   output logic      o_sck,
   output logic      o_ss_n,
   output logic      o_mosi
);
   // Idle levels; the clock only runs inside a frame
   initial begin
      o_sck  = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b0;
   end

   // One frame of i_nclk clocks, 48 ns period, msb first
   task automatic frame(input logic [15:0] i_word, input int i_nclk, output logic [15:0] o_rx);
      int k;
      o_rx = 16'h0000;
      o_ss_n <= 1'b0;
      // Wait for the synchronised output enable before the first edge
      #120;
      for (k = 0; k < i_nclk; k++) begin
         o_sck  <= 1'b1;
         o_mosi <= (k < 16) ? i_word[15 - k] : 1'b0;
         #24;
         o_sck <= 1'b0;
         o_rx = {o_rx[14:0], i_miso};
         #24;
      end
      #30;
      o_ss_n <= 1'b1;
      // Released data line must not hold its last level
      o_mosi <= ~o_mosi;
      #30;
   endtask : frame
endmodule : esf_host_model
`default_nettype wire

/* tb/test_error_status_sys_spi_flags.sv */
// Self-checking bench for the error status word and its serial front end.
// Assumes the host model drives the link and the core clock runs at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "esf_defs.svh"

module test_error_status_sys_spi_flags;
   logic        i_core_clk = 1'b0;
   logic        i_sys_rst  = 1'b1;
   logic        i_meas_done = 1'b0;
   wire logic   sck;
   wire logic   ss_n;
   wire logic   mosi;
   wire logic   miso_wire;
   logic        o_spi_miso;
   logic        o_spi_miso_oe;
   logic        o_meas_start;
   logic        o_meas_pending;
   logic [13:0] o_error_status;
   logic        miso_last = 1'b0;
   logic [15:0] rx;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;

   // ========================================================================
   // Clock, line resolution, instances
   // ========================================================================
   always #12.5 i_core_clk = ~i_core_clk;

   // Undriven reply line shows the inverse so a stale bit cannot pass
   always @(posedge i_core_clk) if (o_spi_miso_oe) miso_last <= o_spi_miso;
   assign miso_wire = o_spi_miso_oe ? o_spi_miso : ~miso_last;

   error_status_sys_spi_flags uut (
      .i_core_clk     (i_core_clk),
      .i_sys_rst      (i_sys_rst),
      .i_spi_sck      (sck),
      .i_spi_ss_n     (ss_n),
      .i_spi_mosi     (mosi),
      .i_meas_done    (i_meas_done),
      .o_spi_miso     (o_spi_miso),
      .o_spi_miso_oe  (o_spi_miso_oe),
      .o_meas_start   (o_meas_start),
      .o_meas_pending (o_meas_pending),
      .o_error_status (o_error_status)
   );

   esf_host_model host (
      .i_miso (miso_wire),
      .o_sck  (sck),
      .o_ss_n (ss_n),
      .o_mosi (mosi)
   );

   // ========================================================================
   // Shared helpers
   // ========================================================================
   task automatic results();
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Command word with even parity over all 16 bits
   function automatic logic [15:0] mk(input logic rw, input logic [13:0] a);
      logic [15:0] w;
      w = {rw, a, 1'b0};
      w[0] = ^w;
      return w;
   endfunction : mk

   // Reply word: data, error flag, parity making the word even
   function automatic logic [15:0] reply(input logic [13:0] d, input logic ef);
      logic [15:0] w;
      w = {d, ef, 1'b0};
      w[0] = ^w;
      return w;
   endfunction : reply

   // Gap after a frame, well above the minimum select high time
   task automatic settle();
      repeat (10) @(posedge i_core_clk);
   endtask : settle

   task automatic send(input logic [15:0] w, input int n);
      host.frame(w, n, rx);
      settle();
   endtask : send

   task automatic clear_flags();
      send(mk(1'b0, `ESF_ADDR_CLR_ERR), 16);
      check({2'h0, o_error_status}, 16'h0000);
   endtask : clear_flags

   // ========================================================================
   // Scenarios
   // ========================================================================
   task automatic t_reset();
      check({13'h0, o_meas_pending, o_spi_miso_oe, o_meas_start}, 16'h0000);
      check({2'h0, o_error_status}, 16'h0000);
   endtask : t_reset

   // Parity fault sticks through a good frame, reads back, then clears
   task automatic t_parity();
      send(mk(1'b0, `ESF_ADDR_NOP) ^ 16'h0001, 16);
      check({2'h0, o_error_status}, 16'h0001);
      send(mk(1'b0, `ESF_ADDR_GAIN), 16);
      check({2'h0, o_error_status}, 16'h0001);
      send(mk(1'b1, `ESF_ADDR_ERR_STAT), 16);
      send(mk(1'b0, `ESF_ADDR_NOP), 16);
      check(rx, reply(14'h0001, 1'b1));
      clear_flags();
   endtask : t_parity

   // Short and long frames both count as clock faults
   task automatic t_clock();
      int n;
      for (n = 15; n <= 17; n += 2) begin
         send(mk(1'b0, `ESF_ADDR_NOP), n);
         check({15'h0, o_error_status[1]}, 16'h0001);
         check({15'h0, o_meas_pending}, 16'h0000);
         clear_flags();
      end
   endtask : t_clock

   // Six known addresses stay quiet, an unknown one raises its flag
   task automatic t_bad_addr();
      logic [13:0] known [6];
      int i;
      known = '{`ESF_ADDR_NOP, `ESF_ADDR_POR_OFF, `ESF_ADDR_SOFT_RST,
                `ESF_ADDR_GAIN, `ESF_ADDR_ERR_STAT, `ESF_ADDR_SYS_CFG};
      for (i = 0; i < 6; i++) begin
         send(mk(1'b1, known[i]), 16);
         check({2'h0, o_error_status}, 16'h0000);
      end
      send(mk(1'b1, 14'h1234), 16);
      check({2'h0, o_error_status}, 16'h0004);
      clear_flags();
   endtask : t_bad_addr

   // Angle read starts one measurement; done ends it
   task automatic t_angle();
      int hits;
      int i;
      host.frame(mk(1'b1, `ESF_ADDR_ANGLE), 16, rx);
      hits = 0;
      for (i = 0; i < 12; i++) begin
         @(negedge i_core_clk);
         if (o_meas_start === 1'b1) hits++;
      end
      check(16'(hits), 16'h0001);
      check({2'h0, o_error_status}, 16'h0010);
      // No second angle read is sent while pending
      @(posedge i_core_clk) i_meas_done <= 1'b1;
      @(posedge i_core_clk) i_meas_done <= 1'b0;
      settle();
      check({13'h0, o_meas_pending, o_error_status[4], 1'b0}, 16'h0000);
   endtask : t_angle

   // Measurement never completes; the full reset command recovers
   task automatic t_stuck();
      send(mk(1'b1, `ESF_ADDR_ANGLE), 16);
      repeat (40) @(posedge i_core_clk);
      check({15'h0, o_meas_pending}, 16'h0001);
      send(mk(1'b0, 14'h3777) ^ 16'h0001, 16);
      send(mk(1'b0, `ESF_ADDR_FULL_RST), 16);
      check({15'h0, o_meas_pending}, 16'h0000);
      check({2'h0, o_error_status}, 16'h0000);
   endtask : t_stuck

   // ========================================================================
   // Main sequence and hang guard
   // ========================================================================
   // Ceiling sits far above the roughly one thousand cycles the run needs
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      t_reset();
      t_parity();
      t_clock();
      t_bad_addr();
      t_angle();
      t_stuck();
      results();
   end
endmodule : test_error_status_sys_spi_flags
`default_nettype wire
